// *** shared/nfc_pkg.sv ***
package nfc_pkg;
    // ---------------------------------------------------------------
    // Clock and timing
    // ---------------------------------------------------------------
    localparam int CLK_MHZ = 25;
    localparam int CLK_PERIOD_NS = 40;
    localparam int ERASE_MAX_US = 3000;
    localparam int RESET_ERASE_MAX_US = 500;
    localparam int RESET_IDLE_MAX_US = 5;
    localparam int WAIT_MARGIN_US = 100;
    localparam int ERASE_WAIT_CYC = (ERASE_MAX_US + WAIT_MARGIN_US) * CLK_MHZ;
    localparam int RESET_WAIT_CYC = (RESET_ERASE_MAX_US + WAIT_MARGIN_US) * CLK_MHZ;
    localparam int BUSY_SEEN_US = 5;
    localparam int BUSY_SEEN_CYC = BUSY_SEEN_US * CLK_MHZ;
    localparam int PHASE_CYC = 2;
    localparam int TO_W = 24;
    // ---------------------------------------------------------------
    // Device commands and fields
    // ---------------------------------------------------------------
    localparam logic [7:0] CMD_ERASE1 = 8'h60;
    localparam logic [7:0] CMD_ERASE2 = 8'hd0;
    localparam logic [7:0] CMD_ID = 8'h90;
    localparam logic [7:0] ADDR_ID = 8'h00;
    localparam logic [7:0] CMD_STATUS = 8'h70;
    localparam logic [7:0] CMD_RESET = 8'hff;
    localparam int SR_FAIL = 0;
    localparam int SR_READY = 6;
    localparam int ID_BYTES = 4;
    // ---------------------------------------------------------------
    // Own register map
    // ---------------------------------------------------------------
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_ROW = 4'h1;
    localparam logic [3:0] REG_STAT = 4'h2;
    localparam logic [3:0] REG_ID = 4'h3;
    localparam logic [3:0] REG_SR = 4'h4;
    localparam int CTL_ERASE = 0;
    localparam int CTL_ID = 1;
    localparam int CTL_STATUS = 2;
    localparam int CTL_RESET = 3;
    // ---------------------------------------------------------------
    // Types
    // ---------------------------------------------------------------
    typedef enum {ST_IDLE, ST_SETUP, ST_WLOW, ST_WHIGH, ST_WAITB, ST_BUSY,
        ST_RLOW, ST_RHIGH} nfc_state_t;
    typedef enum {OP_NONE, OP_ERASE, OP_ID, OP_STATUS, OP_RESET} nfc_op_t;
    typedef struct packed {
        logic cle;
        logic ale;
        logic ce_n;
        logic we_n;
        logic read_strobe_n;
        logic wp_n;
    } nfc_strobe_t;
endpackage

// *** src/nfc_host.sv ***
// Decided for this implementation: the placing of the registers and the strobed register port.
`timescale 1ns/1ns
module nfc_host
(
    // Clock and reset
    input wire logic REF_CLK,
    input wire logic NRST,
    // Software register port
    input wire logic [3:0] ADDR,
    input wire logic [31:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [31:0] RDATA,
    // Flash strobes
    output nfc_pkg::nfc_strobe_t STB,
    // Flash data bus, three signals
    input wire logic [7:0] IO_IN,
    output logic [7:0] IO_OUT,
    output logic IO_OE,
    // Ready/busy, open drain from device
    input wire logic RB_N
);
    // ---------------------------------------------------------------
    // Input synchronisers
    // ---------------------------------------------------------------
    logic [7:0] io_s1_r, io_s2_r; // Data bus sync stages
    logic rb_s1_r, rb_s2_r; // Busy pin sync stages
    // Two stages before any logic reads the pins; busy pin resets to ready
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            io_s1_r <= 8'h00;
            io_s2_r <= 8'h00;
            rb_s1_r <= 1'b1;
            rb_s2_r <= 1'b1;
        end
        else
        begin
            io_s1_r <= IO_IN;
            io_s2_r <= io_s1_r;
            rb_s1_r <= RB_N;
            rb_s2_r <= rb_s1_r;
        end
    end
    // ---------------------------------------------------------------
    // State
    // ---------------------------------------------------------------
    nfc_pkg::nfc_state_t st_r, st_nxt; // Sequencer state
    nfc_pkg::nfc_op_t op_r; // Operation in flight
    logic [2:0] step_r; // Byte index in the write sequence
    logic [1:0] ph_r; // Phase counter for strobe widths
    localparam int TO_LOC = nfc_pkg::TO_W;
    logic [TO_LOC-1:0] to_r; // Timeout counter
    logic [8:0] row_r; // Block number for erase
    logic [31:0] id_r; // Identification bytes
    logic [1:0] idx_r; // Read byte index
    logic [7:0] sr_r; // Last status byte sampled
    logic done_r, tout_r, fail_r, stmode_r; // Status flags
    logic we_n_r, re_n_r, cle_r, ale_r, oe_r; // Strobe drivers
    logic [7:0] dout_r; // Byte on the bus
    // ---------------------------------------------------------------
    // Decode
    // ---------------------------------------------------------------
    wire busy_w = (st_r != nfc_pkg::ST_IDLE);
    // Control writes are refused while an operation is in flight
    wire wr_ctrl = WR && (ADDR == nfc_pkg::REG_CTRL) && !busy_w;
    wire wr_row = WR && (ADDR == nfc_pkg::REG_ROW);
    wire ph_done = (ph_r == 2'(nfc_pkg::PHASE_CYC - 1));
    wire nbytes_is_last;
    // Bytes written per operation: erase four, identify two, others one
    wire [2:0] nbytes_w = (op_r == nfc_pkg::OP_ERASE) ? 3'd4 :
        (op_r == nfc_pkg::OP_ID) ? 3'd2 : 3'd1;
    assign nbytes_is_last = (step_r == nbytes_w - 3'd1);
    // Erase sequence: command, two row cycles, confirm
    wire [7:0] erase_byte = (step_r == 3'd0) ? nfc_pkg::CMD_ERASE1 :
        (step_r == 3'd1) ? {row_r[1:0], 6'h00} :
        (step_r == 3'd2) ? {1'b0, row_r[8:2]} : nfc_pkg::CMD_ERASE2;
    // Only erase, identify, status and reset bytes; never a program
    wire [7:0] seq_byte = (op_r == nfc_pkg::OP_ERASE) ? erase_byte :
        (op_r == nfc_pkg::OP_ID) ? ((step_r == 3'd0) ? nfc_pkg::CMD_ID :
        nfc_pkg::ADDR_ID) :
        (op_r == nfc_pkg::OP_STATUS) ? nfc_pkg::CMD_STATUS : nfc_pkg::CMD_RESET;
    wire seq_cle = !(op_r == nfc_pkg::OP_ERASE && (step_r == 3'd1 || step_r == 3'd2)) &&
        !(op_r == nfc_pkg::OP_ID && step_r == 3'd1);
    wire [TO_LOC-1:0] wait_lim = (op_r == nfc_pkg::OP_ERASE) ?
        TO_LOC'(nfc_pkg::ERASE_WAIT_CYC) : TO_LOC'(nfc_pkg::RESET_WAIT_CYC);
    // ---------------------------------------------------------------
    // Next state
    // ---------------------------------------------------------------
    // Byte sequencer: setup, write pulses, busy wait, read pulses
    always_comb
    begin
        st_nxt = st_r;
        case (st_r)
            nfc_pkg::ST_IDLE: if (wr_ctrl && |WDATA[3:0]) st_nxt = nfc_pkg::ST_SETUP;
            nfc_pkg::ST_SETUP: if (ph_done) st_nxt = nfc_pkg::ST_WLOW;
            nfc_pkg::ST_WLOW: if (ph_done) st_nxt = nfc_pkg::ST_WHIGH;
            nfc_pkg::ST_WHIGH:
                if (ph_done)
                begin
                    if (!nbytes_is_last) st_nxt = nfc_pkg::ST_WLOW;
                    else if (op_r == nfc_pkg::OP_ERASE || op_r == nfc_pkg::OP_RESET)
                        st_nxt = nfc_pkg::ST_WAITB;
                    else st_nxt = nfc_pkg::ST_RLOW;
                end
            // Wait a short time for busy to assert; reset at ready may not
            nfc_pkg::ST_WAITB:
                if (!rb_s2_r || to_r == TO_LOC'(nfc_pkg::BUSY_SEEN_CYC))
                    st_nxt = nfc_pkg::ST_BUSY;
            // Busy pin low for the whole operation
            nfc_pkg::ST_BUSY: if (rb_s2_r || to_r == wait_lim) st_nxt = nfc_pkg::ST_IDLE;
            nfc_pkg::ST_RLOW: if (ph_done) st_nxt = nfc_pkg::ST_RHIGH;
            nfc_pkg::ST_RHIGH:
                if (ph_done && (op_r != nfc_pkg::OP_ID || idx_r == 2'd3))
                    st_nxt = nfc_pkg::ST_IDLE;
                else if (ph_done) st_nxt = nfc_pkg::ST_RLOW;
            default: st_nxt = nfc_pkg::ST_IDLE;
        endcase
    end
    // ---------------------------------------------------------------
    // Sequencer registers
    // ---------------------------------------------------------------
    // State, phase and timeout counters restart on every state change
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_r <= nfc_pkg::ST_IDLE;
            op_r <= nfc_pkg::OP_NONE;
            step_r <= 3'd0;
            ph_r <= 2'd0;
            to_r <= '0;
            idx_r <= 2'd0;
        end
        else
        begin
            st_r <= st_nxt;
            ph_r <= (st_nxt != st_r) ? 2'd0 : ph_r + 2'd1;
            to_r <= (st_nxt != st_r) ? '0 : to_r + TO_LOC'(1);
            if (st_r == nfc_pkg::ST_IDLE && st_nxt == nfc_pkg::ST_SETUP)
            begin
                // Reset wins, then erase, identify, status
                op_r <= WDATA[nfc_pkg::CTL_RESET] ? nfc_pkg::OP_RESET :
                    WDATA[nfc_pkg::CTL_ERASE] ? nfc_pkg::OP_ERASE :
                    WDATA[nfc_pkg::CTL_ID] ? nfc_pkg::OP_ID : nfc_pkg::OP_STATUS;
                step_r <= 3'd0;
                idx_r <= 2'd0;
            end
            if (st_r == nfc_pkg::ST_WHIGH && ph_done && !nbytes_is_last)
                step_r <= step_r + 3'd1;
            if (st_r == nfc_pkg::ST_RHIGH && ph_done)
                idx_r <= idx_r + 2'd1;
        end
    end
    // ---------------------------------------------------------------
    // Pin drivers and captured data
    // ---------------------------------------------------------------
    // Strobes follow the next state so they line up with the state register
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            we_n_r <= 1'b1;
            re_n_r <= 1'b1;
            cle_r <= 1'b0;
            ale_r <= 1'b0;
            oe_r <= 1'b0;
            dout_r <= 8'h00;
            row_r <= 9'h000;
            id_r <= 32'h0;
            sr_r <= 8'h00;
            done_r <= 1'b0;
            tout_r <= 1'b0;
            fail_r <= 1'b0;
            stmode_r <= 1'b0;
        end
        else
        begin
            we_n_r <= !(st_nxt == nfc_pkg::ST_WLOW);
            re_n_r <= !(st_nxt == nfc_pkg::ST_RLOW);
            cle_r <= (st_nxt == nfc_pkg::ST_WLOW || st_nxt == nfc_pkg::ST_WHIGH) && seq_cle;
            ale_r <= (st_nxt == nfc_pkg::ST_WLOW || st_nxt == nfc_pkg::ST_WHIGH) && !seq_cle;
            oe_r <= (st_nxt == nfc_pkg::ST_WLOW || st_nxt == nfc_pkg::ST_WHIGH);
            dout_r <= seq_byte;
            if (wr_row) row_r <= WDATA[8:0];
            // Done flag: set wins over clear
            if (st_r != nfc_pkg::ST_IDLE && st_nxt == nfc_pkg::ST_IDLE) done_r <= 1'b1;
            else if (wr_ctrl) done_r <= 1'b0;
            if (st_r == nfc_pkg::ST_BUSY && st_nxt == nfc_pkg::ST_IDLE && !rb_s2_r)
                tout_r <= 1'b1;
            else if (wr_ctrl) tout_r <= 1'b0;
            // Sample on the rising read strobe edge
            if (st_r == nfc_pkg::ST_RHIGH && ph_r == 2'd0)
            begin
                if (op_r == nfc_pkg::OP_ID) id_r[8*idx_r +: 8] <= io_s2_r;
                else
                begin
                    sr_r <= io_s2_r;
                    fail_r <= io_s2_r[nfc_pkg::SR_FAIL];
                end
            end
            // Device stays in status mode until another command
            if (st_r == nfc_pkg::ST_SETUP && ph_r == 2'd0)
                stmode_r <= (op_r == nfc_pkg::OP_STATUS);
        end
    end
    // ---------------------------------------------------------------
    // Outputs
    // ---------------------------------------------------------------
    assign STB.cle = cle_r;
    assign STB.ale = ale_r;
    // Single device on the bus, so chip select stays active
    assign STB.ce_n = 1'b0;
    assign STB.we_n = we_n_r;
    assign STB.read_strobe_n = re_n_r;
    // Write protect held inactive so erase is accepted
    assign STB.wp_n = 1'b1;
    assign IO_OUT = dout_r;
    // Bus driven only during write bytes
    assign IO_OE = oe_r;
    // Register read data, one cycle after the strobe
    wire [31:0] rd_mux = (ADDR == nfc_pkg::REG_ROW) ? {23'h0, row_r} :
        (ADDR == nfc_pkg::REG_STAT) ? {26'h0, stmode_r, !rb_s2_r, fail_r, tout_r, done_r,
        busy_w} :
        (ADDR == nfc_pkg::REG_ID) ? id_r :
        (ADDR == nfc_pkg::REG_SR) ? {24'h0, sr_r} : 32'h0;
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST) RDATA <= 32'h0;
        else RDATA <= RD ? rd_mux : 32'h0;
    end
    // ---------------------------------------------------------------
    // Checks
    // ---------------------------------------------------------------
    logic [TO_LOC-1:0] low_cnt_r; // Cycles spent in busy wait
    // Busy wait length, for the bound check below
    always_ff @(posedge REF_CLK or negedge NRST)
    begin
        if (!NRST) low_cnt_r <= '0;
        else low_cnt_r <= (st_r == nfc_pkg::ST_BUSY) ? low_cnt_r + TO_LOC'(1) : '0;
    end
    busy_bound_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        low_cnt_r <= TO_LOC'(nfc_pkg::ERASE_WAIT_CYC)) else $error("busy wait overran");
    busy_exit_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (st_r == nfc_pkg::ST_BUSY && !rb_s2_r && to_r != wait_lim) |=> st_r == nfc_pkg::ST_BUSY)
        else $error("left busy early");
    we_excl_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !(cle_r && ale_r)) else $error("cle and ale together");
    re_we_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !(!we_n_r && !re_n_r)) else $error("both strobes low");
    oe_write_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        !re_n_r |-> !oe_r) else $error("driving while reading");
    id_count_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (st_r == nfc_pkg::ST_RHIGH && op_r == nfc_pkg::OP_ID && ph_done && idx_r == 2'd3)
        |=> st_r == nfc_pkg::ST_IDLE) else $error("id read not four bytes");
    done_set_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (st_r != nfc_pkg::ST_IDLE && st_nxt == nfc_pkg::ST_IDLE) |=> done_r)
        else $error("done not set");
    rdata_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (RD && ADDR == nfc_pkg::REG_SR) |=> RDATA == {24'h0, $past(sr_r)})
        else $error("status readback wrong");
    // Each latched byte is driven and has exactly one latch enable
    we_latch_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        $rose(we_n_r) |-> oe_r && (cle_r ^ ale_r))
        else $error("byte latched without one enable");
    // Erase row bytes travel on the address latch
    row_ale_a: assert property (@(posedge REF_CLK) disable iff (!NRST)
        (st_r == nfc_pkg::ST_WHIGH && op_r == nfc_pkg::OP_ERASE && step_r inside {3'd1, 3'd2})
        |-> ale_r && !cle_r) else $error("row byte not on address latch");
    // ---------------------------------------------------------------
    // Cover points
    // ---------------------------------------------------------------
    erase_cov: cover property (@(posedge REF_CLK) disable iff (!NRST)
        op_r == nfc_pkg::OP_ERASE && st_r == nfc_pkg::ST_BUSY ##1 st_r == nfc_pkg::ST_IDLE);
    id_cov: cover property (@(posedge REF_CLK) disable iff (!NRST)
        op_r == nfc_pkg::OP_ID && st_r == nfc_pkg::ST_RHIGH && idx_r == 2'd3);
    rst_cov: cover property (@(posedge REF_CLK) disable iff (!NRST)
        op_r == nfc_pkg::OP_RESET && st_r == nfc_pkg::ST_BUSY);
    stat_cov: cover property (@(posedge REF_CLK) disable iff (!NRST)
        op_r == nfc_pkg::OP_STATUS && st_r == nfc_pkg::ST_RHIGH);
endmodule // nfc_host

// *** bench/nfc_flash_model.sv ***
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Behavioural flash device on the far side of the host
// ---------------------------------------------------------------
module nfc_flash_model
#(
    parameter int ERASE_NS = 16000,
    parameter int RST_NS = 2000,
    parameter logic [31:0] ID_WORD = 32'h17813c5a // Arbitrary identity bytes
)
(
    // Strobes and data from host
    input wire nfc_pkg::nfc_strobe_t stb,
    input wire logic [7:0] bus_in,
    // Data and ready/busy to host
    output logic [7:0] bus_out,
    output logic rb_n,
    // Scenario controls
    input wire logic fail_in,
    input wire logic slow_in
);
    logic busy = 1'b0; // Operation in progress
    logic fail = 1'b0; // Pass/fail of last operation
    logic [1:0] mode = 2'd0; // 0 none, 1 status, 2 identify
    logic [7:0] prev = 8'h00; // Last accepted command other than status
    logic [7:0] adr_q[$]; // Address bytes since that command
    logic [7:0] id_addr = 8'h11; // Address byte given after identify
    logic [8:0] erased_blk = 9'h0; // Block of last erase
    logic drv = 1'b0; // Read strobe window open
    logic [7:0] dat = 8'h00; // Held output byte
    int id_idx = 0; // Next identify byte
    int gen = 0; // Operation generation, stale timers do nothing
    wire [7:0] sr = {stb.wp_n, ~busy, ~busy, 4'h0, fail};
    assign rb_n = ~busy;
    assign bus_out = drv ? ((mode == 2'd1) ? sr : dat) : ~dat;
    // Finish an operation unless aborted meanwhile
    task automatic op(input int g, input int dur, input logic f);
        #(dur);
        if (g == gen)
        begin
            fail = f;
            busy = 1'b0;
        end
    endtask
    // Command and address latch on write strobe rise
    always @(posedge stb.we_n)
    begin
        if (stb.ale)
        begin
            adr_q.push_back(bus_in);
            if (prev == nfc_pkg::CMD_ID)
            begin
                id_addr = bus_in;
                id_idx = 0;
                mode = 2'd2;
            end
        end
        else if (stb.cle && (!busy || bus_in == nfc_pkg::CMD_STATUS ||
            bus_in == nfc_pkg::CMD_RESET))
        begin
            mode = (bus_in == nfc_pkg::CMD_STATUS) ? 2'd1 : 2'd0;
            if (bus_in == nfc_pkg::CMD_ERASE2 && prev == nfc_pkg::CMD_ERASE1 &&
                adr_q.size() >= 2)
            begin
                erased_blk = {adr_q[1][6:0], adr_q[0][7:6]};
                gen++;
                busy = 1'b1;
                fork
                    op(gen, slow_in ? 2 * ERASE_NS : ERASE_NS, fail_in);
                join_none
            end
            if (bus_in == nfc_pkg::CMD_RESET && !(busy && prev == nfc_pkg::CMD_RESET))
            begin
                gen++;
                busy = 1'b1;
                fail = 1'b0;
                fork
                    op(gen, RST_NS, 1'b0);
                join_none
            end
            if (bus_in != nfc_pkg::CMD_STATUS)
            begin
                prev = bus_in;
                adr_q.delete();
            end
        end
    end
    // Drive data from the read strobe fall
    always @(negedge stb.read_strobe_n)
    begin
        drv = 1'b1;
        if (mode == 2'd2 && id_idx < 4)
        begin
            dat = ID_WORD[8 * id_idx +: 8];
            id_idx++;
        end
    end
    // Release after hold, bus shows the inverse
    always @(posedge stb.read_strobe_n)
    begin
        #40;
        dat = bus_out;
        drv = 1'b0;
    end
endmodule // nfc_flash_model

// *** bench/testbench.sv ***
`timescale 1ns/1ns
// ---------------------------------------------------------------
// Host controller bench
// ---------------------------------------------------------------
module testbench;
    localparam logic [31:0] ID_WORD = 32'h17813c5a; // Arbitrary identity bytes
    logic REF_CLK = 1'b0;
    logic NRST = 1'b0;
    logic [3:0] ADDR = 4'h0;
    logic [31:0] WDATA = 32'h0;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [31:0] RDATA;
    nfc_pkg::nfc_strobe_t STB;
    logic [7:0] IO_OUT;
    logic IO_OE;
    logic RB_N;
    logic [7:0] mdl_out; // Device side of the bus
    wire [7:0] io_w = IO_OE ? IO_OUT : mdl_out; // Resolved bus level
    logic fail_in = 1'b0;
    logic slow_in = 1'b0;
    logic [31:0] seed = 32'h5949;
    logic [31:0] rv;
    logic [8:0] blk;
    int mismatches = 0;
    int comparisons = 0;
    always #20 REF_CLK = ~REF_CLK;
    nfc_host i_dut (.REF_CLK(REF_CLK), .NRST(NRST), .ADDR(ADDR), .WDATA(WDATA), .WR(WR),
        .RD(RD), .RDATA(RDATA), .STB(STB), .IO_IN(io_w), .IO_OUT(IO_OUT), .IO_OE(IO_OE),
        .RB_N(RB_N));
    nfc_flash_model #(.ID_WORD(ID_WORD)) i_mdl (.stb(STB), .bus_in(io_w), .bus_out(mdl_out),
        .rb_n(RB_N), .fail_in(fail_in), .slow_in(slow_in));
    // ---------------------------------------------------------------
    // Helpers
    // ---------------------------------------------------------------
    function automatic logic [31:0] xorshift();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp)
        begin
            mismatches++;
            $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask
    // One-cycle register write
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge REF_CLK);
        WR <= 1'b0;
    endtask
    // One-cycle register read, data in the following cycle
    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        @(posedge REF_CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge REF_CLK);
        RD <= 1'b0;
        #1;
        d = RDATA;
    endtask
    // Start an operation and poll until done
    task automatic run(input int bit_no);
        logic [31:0] st;
        wr(nfc_pkg::REG_CTRL, 32'h1 << bit_no);
        rd(nfc_pkg::REG_STAT, st);
        check({31'h0, st[0]}, 32'h1, "busy after start");
        for (int i = 0; i < 2000 && st[1] !== 1'b1; i++)
            rd(nfc_pkg::REG_STAT, st);
        check({28'h0, st[4], st[2:0]}, 32'h2, "done, idle, ready, no timeout");
    endtask
    // Status command then compare the byte
    task automatic stat_chk(input logic [7:0] exp);
        logic [31:0] s;
        run(nfc_pkg::CTL_STATUS);
        rd(nfc_pkg::REG_SR, s);
        check({24'h0, s[7:0]}, {24'h0, exp}, "status byte");
        rd(nfc_pkg::REG_STAT, s);
        check({30'h0, s[5], s[3]}, {30'h0, 1'b1, exp[0]}, "status mode and fail bit");
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask
    // ---------------------------------------------------------------
    // Watchdog
    // ---------------------------------------------------------------
    initial
    begin
        #3000000;
        mismatches++;
        finish_test();
    end
    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial
    begin
        repeat (8) @(posedge REF_CLK);
        NRST <= 1'b1;
        run(nfc_pkg::CTL_ID);
        rd(nfc_pkg::REG_ID, rv);
        check(rv, ID_WORD, "identify bytes");
        check({24'h0, i_mdl.id_addr}, {24'h0, nfc_pkg::ADDR_ID}, "identify address");
        rd(nfc_pkg::REG_STAT, rv);
        check({30'h0, rv[5:4]}, 32'h0, "status mode off and ready");
        check({30'h0, STB.ce_n, STB.wp_n}, 32'h1, "select and protect levels");
        stat_chk(8'he0);
        // Erase rounds: pass, slow fail with resets, pass again
        for (int k = 0; k < 3; k++)
        begin
            rv = xorshift();
            blk = rv[8:0];
            fail_in <= (k == 1);
            slow_in <= (k == 1);
            wr(nfc_pkg::REG_ROW, {23'h0, blk});
            run(nfc_pkg::CTL_ERASE);
            check({23'h0, i_mdl.erased_blk}, {23'h0, blk}, "erased block");
            stat_chk((k == 1) ? 8'he1 : 8'he0);
            rd(nfc_pkg::REG_STAT, rv);
            check({31'h0, rv[3]}, (k == 1) ? 32'h1 : 32'h0, "fail flag");
            if (k == 1)
            begin
                run(nfc_pkg::CTL_RESET);
                run(nfc_pkg::CTL_RESET);
                stat_chk(8'he0);
            end
        end
        finish_test();
    end
endmodule // testbench
